//--- common/slt_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the LSB insert block.
// Assumes: Byte addresses on a 32-bit APB bus, one aligned word per register.
// Notes:   Definitions only; included by bare name.
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define SLT_OFS_LSB_CTRL   12'h160
`define SLT_OFS_CFG        12'h164
`define SLT_OFS_STATUS     12'h168

// ----------------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------------
`define SLT_CTRL_TS_EN     0
`define SLT_CTRL_RESET     8'h00
`define SLT_CFG_RX_EN      0
`define SLT_CFG_CAL_EN     1
`define SLT_CFG_DECIM_ONE  2
`define SLT_CFG_MODE_12    3
`define SLT_CFG_RESET      8'h0C

// ----------------------------------------------------------------------------
// Timing: extra delay cycles after the two-stage synchroniser; FIFO depth and ready fill mark.
// ----------------------------------------------------------------------------
`define SLT_TS_LINE        3
`define SLT_FIFO_DEPTH     8
`define SLT_FIFO_LOW_MARK  4'h5

`endif

//--- common/slt_pkg.sv
// Purpose: Types shared by the LSB insert block.
// Assumes: 12-bit samples; 8-bit modes use the upper eight bits.
// Notes:   Constants live in slt_params.svh.
package slt_pkg;

  // --------------------------------------------------------------------------
  // Sample word carried from the stage into the FIFO.
  // --------------------------------------------------------------------------
  typedef logic [11:0] slt_sample_type;

  // APB answer group.
  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
    logic        slverr;
  } slt_apb_rsp_type;

endpackage

//--- logic/slt_top.sv
// Purpose: Replaces the sample LSB with a latency-matched timestamp or calibration bit.
// Assumes: Samples and cal state are on clk_i; timestamp pin is asynchronous.
// Notes:   Processed samples pass an 8-word FIFO toward the link framer.
`timescale 1ns/10ps
`include "slt_params.svh"

// ----------------------------------------------------------------------------
// Synchronous FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------------
module slt_fifo #(
  parameter int WIDTH = 12,  // Word width.
  parameter int DEPTH = 8    // Entries, power of two.
) (
  input  wire logic             clk_i,     // Clock.
  input  wire logic             srst_i,    // Synchronous reset, active high.
  input  wire logic             s_valid_i, // Write request.
  output logic                  s_ready_o, // Room for a word.
  input  wire logic [WIDTH-1:0] s_data_i,  // Write word.
  output logic                  m_valid_o, // Word available.
  input  wire logic             m_ready_i, // Reader takes word.
  output logic [WIDTH-1:0]      m_data_o,  // Read word.
  output logic [$clog2(DEPTH):0] count_o   // Fill level.
);
  localparam int AW = $clog2(DEPTH);

  // Pointer and count state in one struct; the storage array stands apart.
  typedef struct packed {
    logic [AW-1:0] wr;   // Write pointer.
    logic [AW-1:0] rd;   // Read pointer.
    logic [AW:0]   cnt;  // Occupancy.
  } slt_fifo_st_type;

  slt_fifo_st_type  st_q;              // Registered pointers.
  slt_fifo_st_type  st_d;              // Next pointers.
  logic [WIDTH-1:0] mem [DEPTH];       // Storage array.
  logic             push;              // Accepted write.
  logic             pop;               // Accepted read.

  // Full exactly when the count reaches the depth.
  assign s_ready_o = (st_q.cnt != (AW+1)'(DEPTH));
  assign m_valid_o = (st_q.cnt != '0);
  assign m_data_o  = mem[st_q.rd];
  assign count_o   = st_q.cnt;
  assign push      = s_valid_i & s_ready_o;
  assign pop       = m_valid_o & m_ready_i;

  // Pointer and count update; full and empty follow the count exactly.
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = st_q.wr + AW'(1);
    end
    if (pop) begin
      st_d.rd = st_q.rd + AW'(1);
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointer registers and storage writes.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
    if (push) begin
      mem[st_q.wr] <= s_data_i;
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Top: APB registers, timestamp alignment, LSB insertion, output FIFO.
// ----------------------------------------------------------------------------
module slt_top (
  input  wire logic        clk_i,          // Output sample clock, 100 MHz.
  input  wire logic        srst_i,         // Synchronous reset, active high.
  input  wire logic        psel,           // APB select.
  input  wire logic        penable,        // APB access phase.
  input  wire logic        pwrite,         // APB direction, high for write.
  input  wire logic [11:0] paddr,          // APB byte address.
  input  wire logic [31:0] pwdata,         // APB write data.
  output logic             pready,         // APB ready, registered.
  output logic [31:0]      prdata,         // APB read data, registered.
  output logic             pslverr,        // APB error on unmapped address.
  input  wire logic        timestamp_i,    // Asynchronous timestamp pin.
  input  wire logic        cal_state_i,    // Calibration state bit, same clock.
  input  wire logic        sample_valid_i, // Converter sample present.
  output logic             sample_ready_o, // Block can take a sample.
  input  wire logic [11:0] sample_data_i,  // Converter sample, full resolution.
  output logic             out_valid_o,    // Processed sample available.
  input  wire logic        out_ready_i,    // Framer takes processed sample.
  output logic [11:0]      out_data_o,     // Processed sample.
  output logic             ila_cs_o        // Control-bit count for lane alignment.
);

  // --------------------------------------------------------------------------
  // Block state.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]               ctrl;    // Control register, timestamp enable in bit 0.
    logic [7:0]               cfg;     // Receiver, cal, decimation and width settings.
    logic                     meta1;   // Synchroniser first stage.
    logic                     meta2;   // Synchroniser second stage.
    logic [`SLT_TS_LINE-1:0]  line;    // Latency-matching delay line.
    logic                     stg_vld; // Stage holds a word.
    slt_pkg::slt_sample_type  stg;     // Processed word.
    logic                     in_rdy;  // Registered sample ready.
    slt_pkg::slt_apb_rsp_type rsp;     // APB answer.
    logic                     ila_cs;  // Advertised control-bit count.
  } slt_st_type;

  slt_st_type              st_q;        // Registered state.
  slt_st_type              st_d;        // Next state.
  logic                    ts_aligned;  // Timestamp aligned to the sample.
  logic                    ts_active;   // Timestamp insertion in force.
  logic                    cal_active;  // Calibration insertion in force.
  logic                    take;        // Sample accepted this cycle.
  logic                    fifo_rdy;    // FIFO has room.
  logic [3:0]              fifo_cnt;    // FIFO fill level.
  logic                    ctrl_bit;    // Bit placed in the LSB.
  logic                    wr_acc;      // APB write completes.
  slt_pkg::slt_sample_type word;        // Sample after insertion.

  assign ts_aligned = st_q.line[`SLT_TS_LINE-1];
  // Decimation other than one disables timestamp insertion; calibration insertion still applies.
  assign ts_active  = st_q.ctrl[`SLT_CTRL_TS_EN] & st_q.cfg[`SLT_CFG_DECIM_ONE];
  assign cal_active = st_q.cfg[`SLT_CFG_CAL_EN];
  // Timestamp takes priority over calibration state.
  assign ctrl_bit   = ts_active ? ts_aligned : cal_state_i;
  assign take       = sample_valid_i & st_q.in_rdy;
  assign wr_acc     = psel & penable & pwrite & st_q.rsp.ready;

  // --------------------------------------------------------------------------
  // LSB insertion for both widths.
  // --------------------------------------------------------------------------
  // The 8-bit mode keeps the upper eight converter bits in the low byte.
  always_comb begin
    word = sample_data_i;
    if (!st_q.cfg[`SLT_CFG_MODE_12]) begin
      word = {4'h0, sample_data_i[11:4]};
    end
    if (ts_active || cal_active) begin
      word[0] = ctrl_bit;
    end
  end

  // --------------------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // The pin passes two bare flip-flops before any gate reads it, so a
    // metastable first stage never fans out into logic.
    st_d.meta1 = timestamp_i;
    st_d.meta2 = st_q.meta1;
    // The receiver enable gates the synchronised pin; when it is off a
    // steady zero reaches the samples.
    // Two sync stages plus this line equal the sample's own latency.
    st_d.line = {st_q.line[`SLT_TS_LINE-2:0], st_q.meta2 & st_q.cfg[`SLT_CFG_RX_EN]};
    // Stage drains into the FIFO, then reloads from an accepted sample.
    if (st_q.stg_vld && fifo_rdy) begin
      st_d.stg_vld = 1'b0;
    end
    if (take) begin
      st_d.stg_vld = 1'b1;
      st_d.stg     = word;
    end
    // Ready is issued only with room for stage and in-flight words.
    st_d.in_rdy = (fifo_cnt <= `SLT_FIFO_LOW_MARK) && !(st_q.stg_vld && !fifo_rdy);
    // Lane alignment never advertises the inserted control bit.
    st_d.ila_cs = 1'b0;
    // APB: setup cycle prepares the answer, access cycle completes it.
    st_d.rsp.ready = 1'b0;
    if (psel && !penable) begin
      st_d.rsp.ready  = 1'b1;
      st_d.rsp.slverr = 1'b0;
      case (paddr)
        `SLT_OFS_LSB_CTRL: begin
          st_d.rsp.rdata = {24'h000000, st_q.ctrl};
        end
        `SLT_OFS_CFG: begin
          st_d.rsp.rdata = {24'h000000, st_q.cfg};
        end
        `SLT_OFS_STATUS: begin
          st_d.rsp.rdata = {26'h0, fifo_cnt, st_q.stg_vld, ts_aligned};
        end
        default: begin
          st_d.rsp.rdata  = 32'h00000000;
          st_d.rsp.slverr = 1'b1;
        end
      endcase
    end
    // Reserved control bits are stored and read back as written.
    if (wr_acc) begin
      case (paddr)
        `SLT_OFS_LSB_CTRL: begin
          st_d.ctrl = pwdata[7:0];
        end
        `SLT_OFS_CFG: begin
          st_d.cfg = pwdata[7:0];
        end
        default: begin
          st_d.ctrl = st_q.ctrl;
        end
      endcase
    end
  end

  // State register; control starts with insertion disabled.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q      <= '0;
      st_q.ctrl <= `SLT_CTRL_RESET;
      st_q.cfg  <= `SLT_CFG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Output buffer toward the framer.
  // --------------------------------------------------------------------------
  slt_fifo #(
    .WIDTH (12),
    .DEPTH (`SLT_FIFO_DEPTH)
  ) u_fifo (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .s_valid_i (st_q.stg_vld),
    .s_ready_o (fifo_rdy),
    .s_data_i  (st_q.stg),
    .m_valid_o (out_valid_o),
    .m_ready_i (out_ready_i),
    .m_data_o  (out_data_o),
    .count_o   (fifo_cnt)
  );

  assign pready         = st_q.rsp.ready;
  assign prdata         = st_q.rsp.rdata;
  assign pslverr        = st_q.rsp.slverr;
  assign sample_ready_o = st_q.in_rdy;
  assign ila_cs_o       = st_q.ila_cs;

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  property p_ts_lsb;
    @(posedge clk_i) disable iff (srst_i)
      take && ts_active |=> st_q.stg[0] == $past(ts_aligned);
  endproperty
  a_ts_lsb: assert property (p_ts_lsb) else $error("Timestamp missing in LSB.");

  property p_decim;
    @(posedge clk_i) disable iff (srst_i)
      take && !st_q.cfg[`SLT_CFG_DECIM_ONE] && !cal_active
        |=> st_q.stg[0] == ($past(st_q.cfg[`SLT_CFG_MODE_12]) ? $past(sample_data_i[0])
                                                            : $past(sample_data_i[4]));
  endproperty
  a_decim: assert property (p_decim) else $error("LSB altered without bypass.");

  property p_prio;
    @(posedge clk_i) disable iff (srst_i)
      take && ts_active && cal_active && (ts_aligned != cal_state_i)
        |=> st_q.stg[0] != $past(cal_state_i);
  endproperty
  a_prio: assert property (p_prio) else $error("Cal state beat timestamp.");

  property p_align;
    @(posedge clk_i) disable iff (srst_i)
      !srst_i [*5]
        |=> ts_aligned == ($past(timestamp_i, 5) & $past(st_q.cfg[`SLT_CFG_RX_EN], 3));
  endproperty
  a_align: assert property (p_align) else $error("Timestamp latency mismatch.");

  property p_w8;
    @(posedge clk_i) disable iff (srst_i)
      take && !st_q.cfg[`SLT_CFG_MODE_12]
        |=> st_q.stg[11:1] == {4'h0, $past(sample_data_i[11:5])};
  endproperty
  a_w8: assert property (p_w8) else $error("8-bit sample data wrong.");

  property p_w12;
    @(posedge clk_i) disable iff (srst_i)
      take && st_q.cfg[`SLT_CFG_MODE_12]
        |=> st_q.stg[11:1] == $past(sample_data_i[11:1]);
  endproperty
  a_w12: assert property (p_w12) else $error("12-bit sample data wrong.");

  property p_ila;
    @(posedge clk_i) disable iff (srst_i)
      st_q.ctrl[`SLT_CTRL_TS_EN] |-> ##1 (ila_cs_o == 1'b0) [*2];
  endproperty
  a_ila: assert property (p_ila) else $error("Control bit advertised.");

  property p_rst;
    @(posedge clk_i)
      srst_i |=> st_q.ctrl == `SLT_CTRL_RESET && !ts_active;
  endproperty
  a_rst: assert property (p_rst) else $error("Control not cleared by reset.");

  property p_pass;
    @(posedge clk_i) disable iff (srst_i)
      take && !ts_active && !cal_active && st_q.cfg[`SLT_CFG_MODE_12]
        |=> st_q.stg == $past(sample_data_i);
  endproperty
  a_pass: assert property (p_pass) else $error("Sample not passed unchanged.");

  // A write to the control register must land at the completing edge.
  property p_wr_ctrl;
    @(posedge clk_i) disable iff (srst_i)
      wr_acc && paddr == `SLT_OFS_LSB_CTRL |=> st_q.ctrl == $past(pwdata[7:0]);
  endproperty
  a_wr_ctrl: assert property (p_wr_ctrl) else $error("Control write lost.");

  property p_rdy_one;
    @(posedge clk_i) disable iff (srst_i)
      pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("Ready held past one cycle.");

  property p_no_ovr;
    @(posedge clk_i) disable iff (srst_i)
      take |-> !(st_q.stg_vld && !fifo_rdy);
  endproperty
  a_no_ovr: assert property (p_no_ovr) else $error("Sample overwrote a stalled stage.");

endmodule

//--- test/slt_link_sink.sv
// Purpose: Framer-side model that drains processed samples from the block.
// Assumes: Same clock as the block; ready is the only thing it drives.
// Notes:   Can answer promptly, every other cycle, or stall outright.
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Link sink.
// ----------------------------------------------------------------------------
module slt_link_sink (
  input  wire logic clk_i,   // Sample clock.
  input  wire logic srst_i,  // Synchronous reset, active high.
  input  wire logic hold_i,  // Stall the link completely.
  input  wire logic slow_i,  // Take a word only every other cycle.
  output logic      ready_o  // Framer takes the head word.
);
  logic phase_q;  // Toggles each cycle to pace the slow mode.

  // The phase runs freely so slow draining interleaves with FIFO refills.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  // A real framer stalls at will, so ready never waits for valid.
  assign ready_o = ~srst_i & ~hold_i & (~slow_i | phase_q);
endmodule

//--- test/tb_top.sv
// Purpose: Self-checking bench for the LSB insert block.
// Assumes: Zero-wait APB slave; framer side modelled by slt_link_sink.
// Notes:   Scenarios run in order; each drives, waits and judges itself.
`timescale 1ns/10ps
`include "slt_params.svh"

module tb_top;
  // --------------------------------------------------------------------------
  // Signals.
  // --------------------------------------------------------------------------
  logic                    clk_i, srst_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic                    ts_pin, cal_pin, s_valid, s_ready, o_valid, o_ready;
  logic                    ila_cs, hold, slow, er;
  slt_pkg::slt_sample_type s_data, o_data;
  slt_pkg::slt_sample_type rx_q[$];  // Words taken by the sink, in order.
  int                      err_total, compares;

  slt_top u_slt_top (.clk_i(clk_i), .srst_i(srst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timestamp_i(ts_pin), .cal_state_i(cal_pin),
    .sample_valid_i(s_valid), .sample_ready_o(s_ready), .sample_data_i(s_data),
    .out_valid_o(o_valid), .out_ready_i(o_ready), .out_data_o(o_data), .ila_cs_o(ila_cs));
  slt_link_sink u_slt_link_sink (.clk_i(clk_i), .srst_i(srst_i), .hold_i(hold),
    .slow_i(slow), .ready_o(o_ready));

  // Clock at 100 MHz.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Record every word the sink accepts at a rising edge.
  always @(posedge clk_i) begin
    if (o_valid === 1'b1 && o_ready === 1'b1) rx_q.push_back(o_data);
  end

  // --------------------------------------------------------------------------
  // Reporting and comparison.
  // --------------------------------------------------------------------------
  task automatic close_out;
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic fail(string m);
    err_total++;
    $display("FAIL %0t %s", $time, m);
  endtask

  task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("register %h expected %h", got, exp));
  endtask

  task automatic chk_smp(slt_pkg::slt_sample_type got, slt_pkg::slt_sample_type exp);
    compares++;
    if (got !== exp) fail($sformatf("sample %h expected %h", got, exp));
  endtask

  task automatic chk_bit(logic got, logic exp);
    compares++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask

  // --------------------------------------------------------------------------
  // APB master: setup, then access held until pready is seen high.
  // --------------------------------------------------------------------------
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Ready is read at the rising edge itself, where the slave samples too.
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail("apb hang");
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Program both registers and the pins, then let the timestamp pipe settle.
  task automatic setup(logic [7:0] cfg, logic [7:0] ctl, logic ts, logic cal);
    apb(1'b1, `SLT_OFS_CFG, {24'h0, cfg});
    apb(1'b1, `SLT_OFS_LSB_CTRL, {24'h0, ctl});
    @(posedge clk_i);
    ts_pin <= ts;
    cal_pin <= cal;
    repeat (8) @(posedge clk_i);
  endtask

  // Stream n samples back to back; mark >= 0 pulses the pin with the first.
  task automatic run(int n, logic [11:0] base, logic m12, logic ins, logic b, int mark);
    int k;
    slt_pkg::slt_sample_type s, e;
    @(posedge clk_i);
    s_valid <= 1'b1;
    s_data <= base;
    if (mark >= 0) ts_pin <= 1'b1;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (s_ready !== 1'b1 && k < 64);
      if (k >= 64) begin
        fail("sample refused");
        close_out();
      end
      if (mark >= 0) ts_pin <= 1'b0;
      s_data <= base + 12'(2 * (i + 1));
      if (i == n - 1) s_valid <= 1'b0;
    end
    k = 0;
    while (rx_q.size() < n && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 300) begin
      fail("sink timeout");
      close_out();
    end
    chk_bit(1'(rx_q.size() == n), 1'b1);
    for (int i = 0; i < n && rx_q.size() > 0; i++) begin
      s = base + 12'(2 * i);
      if (mark >= 0) b = 1'(i == mark);
      if (m12) e = ins ? {s[11:1], b} : s;
      else e = ins ? {4'h0, s[11:5], b} : {4'h0, s[11:4]};
      chk_smp(rx_q.pop_front(), e);
    end
    chk_bit(ila_cs, 1'b0);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------------
  task automatic sc_regs;
    apb(1'b0, `SLT_OFS_LSB_CTRL, 32'h0);
    chk_reg(rd, 32'h0000_0000);
    apb(1'b0, `SLT_OFS_CFG, 32'h0);
    chk_reg(rd, 32'h0000_000C);
    apb(1'b0, 12'h170, 32'h0);
    chk_bit(er, 1'b1);
    chk_reg(rd, 32'h0000_0000);
    apb(1'b0, `SLT_OFS_STATUS, 32'h0);
    chk_bit(er, 1'b0);
    chk_reg(rd, 32'h0000_0000);
    apb(1'b1, `SLT_OFS_LSB_CTRL, 32'h0000_00FE);
    apb(1'b0, `SLT_OFS_LSB_CTRL, 32'h0);
    chk_reg(rd, 32'h0000_00FE);
  endtask

  task automatic sc_modes;
    setup(8'h0C, 8'h00, 1'b1, 1'b1);
    run(8, 12'hA51, 1'b1, 1'b0, 1'b0, -1);
    setup(8'h0D, 8'h01, 1'b1, 1'b0);
    run(8, 12'h3C4, 1'b1, 1'b1, 1'b1, -1);
    setup(8'h0D, 8'h01, 1'b0, 1'b0);
    run(8, 12'h7A3, 1'b1, 1'b1, 1'b0, -1);
    run(8, 12'h100, 1'b1, 1'b1, 1'b0, 5);
    setup(8'h0F, 8'h01, 1'b0, 1'b1);
    run(8, 12'h5B7, 1'b1, 1'b1, 1'b0, -1);
    setup(8'h0F, 8'h00, 1'b0, 1'b1);
    run(8, 12'h200, 1'b1, 1'b1, 1'b1, -1);
    setup(8'h09, 8'h01, 1'b1, 1'b0);
    run(8, 12'h442, 1'b1, 1'b0, 1'b0, -1);
    setup(8'h0C, 8'h01, 1'b1, 1'b0);
    run(8, 12'h9E1, 1'b1, 1'b1, 1'b0, -1);
    setup(8'h05, 8'h01, 1'b1, 1'b0);
    run(8, 12'hC38, 1'b0, 1'b1, 1'b1, -1);
    setup(8'h05, 8'h00, 1'b1, 1'b0);
    run(8, 12'hC38, 1'b0, 1'b0, 1'b0, -1);
  endtask

  // Fill the FIFO against a stalled sink, then drain it slowly.
  task automatic sc_fifo;
    int acc;
    int k;
    acc = 0;
    k = 0;
    setup(8'h0C, 8'h00, 1'b0, 1'b0);
    hold <= 1'b1;
    s_valid <= 1'b1;
    s_data <= 12'h301;
    // A word is taken at every rising edge that sees ready high.
    for (int c = 0; c < 30; c++) begin
      @(posedge clk_i);
      if (s_ready === 1'b1) acc++;
      s_data <= 12'h301 + 12'(2 * acc);
    end
    s_valid <= 1'b0;
    // The FIFO plus the stage bound what a stalled link can absorb.
    chk_bit(1'(acc > 0 && acc <= `SLT_FIFO_DEPTH + 1), 1'b1);
    chk_bit(o_valid, 1'b1);
    slow <= 1'b1;
    hold <= 1'b0;
    while (rx_q.size() < acc && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 300) begin
      fail("drain timeout");
      close_out();
    end
    chk_bit(1'(rx_q.size() == acc), 1'b1);
    for (int i = 0; i < acc && rx_q.size() > 0; i++) begin
      chk_smp(rx_q.pop_front(), 12'h301 + 12'(2 * i));
    end
    // One edge more, so the flag shows the FIFO after the last pop.
    @(posedge clk_i);
    chk_bit(o_valid, 1'b0);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog.
  // --------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ts_pin, cal_pin} = '0;
    {s_valid, s_data, hold, slow, err_total, compares} = '0;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    sc_regs();
    sc_modes();
    sc_fifo();
    close_out();
  end

  // Cuts a hang short; the limit is far above the whole sequence.
  initial begin
    repeat (20000) @(posedge clk_i);
    fail("watchdog");
    close_out();
  end
endmodule
